//--- verilog/uis_map.vh
// Register map, field positions and reset values of the interrupt status block
`ifndef UIS_MAP_VH
`define UIS_MAP_VH

`define UIS_ADDR_W         12
`define UIS_OFS_MASK       12'h038
`define UIS_OFS_RAW        12'h03C
`define UIS_OFS_MIS        12'h040
`define UIS_OFS_CLR        12'h044
`define UIS_OFS_ID4        12'hFD0

`define UIS_SRC_N          7
`define UIS_SRC_LSB        4
`define UIS_SRC_MSB        10
`define UIS_BIT_OVERRUN    10
`define UIS_BIT_BREAK      9
`define UIS_BIT_PARITY     8
`define UIS_BIT_FRAMING    7
`define UIS_BIT_RXTIMEOUT  6
`define UIS_BIT_TRANSMIT   5
`define UIS_BIT_RECEIVE    4

`define UIS_RST_STATUS     7'h00
`define UIS_RST_MASK       7'h00
`define UIS_RST_RDATA      32'h0000_0000
`define UIS_ID_WIDTH       8

`endif

//--- verilog/uis_src_bit.v
// One sticky interrupt source bit with write-one-to-clear
`timescale 1ns/10ps
`default_nettype none
module uis_src_bit
(
  input  wire clk_i,
  input  wire rstn_i,
  input  wire set_i,
  input  wire clr_i,
  output reg  raw_o
);

  // Set wins over a clear in the same cycle
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      raw_o <= 1'b0;
    else if (set_i)
      raw_o <= 1'b1;
    else if (clr_i)
      raw_o <= 1'b0;
  end

endmodule
`default_nettype wire

//--- verilog/uis_pulse_sync.v
// Two-flop synchroniser with rising-edge detect for one event input
`timescale 1ns/10ps
`default_nettype none
module uis_pulse_sync
(
  input  wire clk_i,
  input  wire rstn_i,
  input  wire async_i,
  output reg  pulse_o
);

  reg meta_reg;
  reg sync_reg;
  reg sync_dly_reg;

  // Delayed copy gives a single pulse per rising edge, not a level held while high
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      meta_reg     <= 1'b0;
      sync_reg     <= 1'b0;
      sync_dly_reg <= 1'b0;
      pulse_o      <= 1'b0;
    end
    else
    begin
      meta_reg     <= async_i;
      sync_reg     <= meta_reg;
      sync_dly_reg <= sync_reg;
      pulse_o      <= sync_reg & ~sync_dly_reg;
    end
  end

endmodule
`default_nettype wire

//--- verilog/uis_irq_status.v
// Interrupt status, mask and clear registers with one combined interrupt
//
// Chosen here: the Avalon-MM slave port.
`timescale 1ns/10ps
`default_nettype none
`include "uis_map.vh"
module uis_irq_status
#(
  parameter [`UIS_ID_WIDTH-1:0] ID_LOW = 8'hA5  // Arbitrary identification value
)
(
  input  wire                   clk_i,
  input  wire                   rstn_i,
  input  wire [`UIS_ADDR_W-1:0] avs_address_i,
  input  wire                   avs_read_i,
  input  wire                   avs_write_i,
  input  wire [31:0]            avs_writedata_i,
  input  wire [3:0]             avs_byteenable_i,
  output reg  [31:0]            avs_readdata_o,
  output reg                    avs_waitrequest_o,
  input  wire [6:0]             src_event_i,
  output reg  [6:0]             raw_status_o,
  output reg                    irq_o
);

  //--------------------------------------------------------------
  // Bus handshake: one wait cycle, answer on the second edge
  //--------------------------------------------------------------
  reg         ack_reg;
  wire        req    = (avs_read_i | avs_write_i) & ~ack_reg;
  wire        wr_hit = avs_write_i & ~ack_reg;
  wire [6:0]  raw_w;
  reg  [6:0]  mask_reg;
  wire [6:0]  mis_w  = raw_w & mask_reg;
  wire [6:0]  ev_w;
  wire [6:0]  clr_w;
  reg  [31:0] rdata_next;

  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= req;
  end

  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      avs_waitrequest_o <= 1'b1;
    else
      avs_waitrequest_o <= ~req;
  end

  //--------------------------------------------------------------
  // Clear strobes, bit-aligned with status
  //--------------------------------------------------------------
  wire clr_hit = wr_hit & (avs_address_i == `UIS_OFS_CLR);
  wire [7:0] clr_be = {{3{avs_byteenable_i[1]}}, {5{avs_byteenable_i[0]}}};
  assign clr_w = {7{clr_hit}} &
                 avs_writedata_i[`UIS_SRC_MSB:`UIS_SRC_LSB] & clr_be[7:1];

  //--------------------------------------------------------------
  // Source bits
  //--------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `UIS_SRC_N; g = g + 1)
    begin : gen_src
      uis_pulse_sync u_sync
      (
        .clk_i   (clk_i),
        .rstn_i  (rstn_i),
        .async_i (src_event_i[g]),
        .pulse_o (ev_w[g])
      );
      uis_src_bit u_bit
      (
        .clk_i  (clk_i),
        .rstn_i (rstn_i),
        .set_i  (ev_w[g]),
        .clr_i  (clr_w[g]),
        .raw_o  (raw_w[g])
      );
    end
  endgenerate

  //--------------------------------------------------------------
  // Mask register
  //--------------------------------------------------------------
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      mask_reg <= `UIS_RST_MASK;
    else if (wr_hit && (avs_address_i == `UIS_OFS_MASK))
    begin
      if (avs_byteenable_i[0])
        mask_reg[3:0] <= avs_writedata_i[7:4];
      if (avs_byteenable_i[1])
        mask_reg[6:4] <= avs_writedata_i[10:8];
    end
  end

  //--------------------------------------------------------------
  // Read decode; raw and masked views ignore writes
  //--------------------------------------------------------------
  always @*
  begin
    rdata_next = `UIS_RST_RDATA;
    if (avs_address_i == `UIS_OFS_MIS)
      rdata_next[`UIS_SRC_MSB:`UIS_SRC_LSB] = mis_w;
    else if (avs_address_i == `UIS_OFS_RAW)
      rdata_next[`UIS_SRC_MSB:`UIS_SRC_LSB] = raw_w;
    else if (avs_address_i == `UIS_OFS_MASK)
      rdata_next[`UIS_SRC_MSB:`UIS_SRC_LSB] = mask_reg;
    else if (avs_address_i == `UIS_OFS_ID4)
      rdata_next[`UIS_ID_WIDTH-1:0] = ID_LOW;
  end

  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
      avs_readdata_o <= `UIS_RST_RDATA;
    else if (avs_read_i && !ack_reg)
      avs_readdata_o <= rdata_next;
  end

  //--------------------------------------------------------------
  // Outputs
  //--------------------------------------------------------------
  always @(posedge clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      irq_o        <= 1'b0;
      raw_status_o <= `UIS_RST_STATUS;
    end
    else
    begin
      irq_o        <= |mis_w;
      raw_status_o <= raw_w;
    end
  end

endmodule
`default_nettype wire

//--- dv/uis_irq_status_asserts.sv
// Port checks of the interrupt status block
`timescale 1ns/10ps
`default_nettype none
module uis_irq_status_asserts #(parameter [7:0] ID_LOW = 8'hA5)
(
  input wire logic        clk_i,
  input wire logic        rstn_i,
  input wire logic [11:0] avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic [6:0]  raw_status_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  wire        rd = avs_read_i && !avs_waitrequest_o;
  wire        wc = avs_write_i && !avs_waitrequest_o && avs_address_i == 12'h044;
  wire [11:0] a  = avs_address_i;
  wire [31:0] q  = avs_readdata_o;
  wire [6:0]  r  = raw_status_o;
  wire [6:0]  w  = avs_writedata_i[10:4];
  property p_rst; $rose(rstn_i) |-> r == 7'h00 && !irq_o; endproperty
  a_rst: assert property (p_rst) else $error("reset");
  property p_res; rd && a != 12'hFD0 |-> q[31:11] == 0 && q[3:0] == 0; endproperty
  a_res: assert property (p_res) else $error("reserved");
  property p_id; rd && a == 12'hFD0 |-> q == {24'h0, ID_LOW}; endproperty
  a_id: assert property (p_id) else $error("ident");
  property p_mis; rd && a == 12'h040 |-> (q[10:4] & ~r) == 0; endproperty
  a_mis: assert property (p_mis) else $error("masked");
  property p_ro; avs_write_i && (a == 12'h040 || a == 12'h03C) |-> ##2 $stable(r); endproperty
  a_ro: assert property (p_ro) else $error("read only");
  property p_clr1; wc |-> ##2 (r & $past(w, 2)) == 0; endproperty
  a_clr1: assert property (p_clr1) else $error("clear");
  property p_clr0; wc |-> ##2 ((r ^ $past(r, 2)) & ~$past(w, 2)) == 0; endproperty
  a_clr0: assert property (p_clr0) else $error("zero");
  property p_irq; irq_o |-> r != 7'h00; endproperty
  a_irq: assert property (p_irq) else $error("irq");
endmodule
bind uis_irq_status uis_irq_status_asserts #(.ID_LOW(ID_LOW)) u_chk (.*);
`default_nettype wire

//--- dv/uis_src_model.sv
// Event line model of the serial core
`timescale 1ns/10ps
`default_nettype none
module uis_src_model
(
  input  wire logic       clk_i,
  input  wire logic [6:0] fire_i,
  output var  logic [6:0] src_o
);
  always @(posedge clk_i)
    src_o <= fire_i;
endmodule
`default_nettype wire

//--- dv/uis_irq_status_tb.sv
// Bench for the interrupt status block
`timescale 1ns/10ps
`default_nettype none
module uis_irq_status_tb;
  logic        clk_i = 0, rstn_i = 0, rd = 0, wr = 0, irq, wq;
  logic [11:0] ad = 0;
  logic [31:0] wd = 0, rdo, q;
  logic [6:0]  fire = 0, src, raw;
  int          fails = 0, check_count = 0, i;
  always #2.5 clk_i = !clk_i;
  uis_src_model u_src (.clk_i(clk_i), .fire_i(fire), .src_o(src));
  uis_irq_status u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .avs_address_i(ad),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
    .avs_readdata_o(rdo), .avs_waitrequest_o(wq), .src_event_i(src),
    .raw_status_o(raw), .irq_o(irq));
  task chk(input logic [31:0] s, e);
    check_count++;
    fails += (s !== e);
    if (s !== e)
      $display("wrong value %0t %h %h", $time, s, e);
  endtask
  task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
    {ad, wr, rd, wd} <= {a, w, !w, d};
    do @(posedge clk_i); while (wq !== 1'b0);
    q = rdo;
    {rd, wr} <= 2'h0;
    @(posedge clk_i);
  endtask
  task pulse(input logic [6:0] f);
    fire <= f;
    repeat (2) @(posedge clk_i);
    fire <= 7'h00;
    repeat (8) @(posedge clk_i);
  endtask
  task final_report;
    if (fails == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial
  begin
    #20000;
    fails++;
    final_report;
  end
  initial
  begin
    repeat (4) @(posedge clk_i);
    rstn_i <= 1'b1;
    @(posedge clk_i);
    acc(0, 12'h040, 0);
    chk(q, 0);
    acc(0, 12'hFD0, 0);
    chk(q, 32'h0000_00A5);
    acc(0, 12'h100, 0);
    chk(q, 0);
    acc(1, 12'h038, 32'h0000_05F0);
    pulse(7'h7F);
    chk(irq, 1);
    acc(1, 12'h040, 32'hFFFF_FFFF);
    acc(1, 12'h03C, 0);
    acc(1, 12'h044, 0);
    acc(0, 12'h03C, 0);
    chk(q, 32'h0000_07F0);
    acc(0, 12'h040, 0);
    chk(q, 32'h0000_05F0);
    for (i = 4; i < 11; i++)
    begin
      acc(1, 12'h044, 32'h1 << i);
      acc(0, 12'h040, 0);
      chk(q, 32'h5F0 & ~((32'h2 << i) - 1));
    end
    chk(irq, 0);
    pulse(7'h20);
    chk(raw, 7'h20);
    chk(irq, 0);
    final_report;
  end
endmodule
`default_nettype wire
